// [core/ddw_host.sv]
// host controller that writes 16-bit control words into a dual dac over a 3-wire link
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] The serial clock idles low and each data bit is stable at its falling edge.
// [RULE2] Each data bit is set up before the falling clock edge at which the dac samples it.
// [RULE3] Frame select is driven low before the first data bit is sent.
// [RULE4] In byte mode select stays low after the first byte and a second byte follows.
// [RULE5] Select rises only after the second byte, or the whole word, is finished.
// [RULE6] The word leaves most significant bit first.
// [RULE7] A port that shifts least significant bit first gets each byte reversed first.
// [RULE8] Data changes only away from the falling edge, as a falling-edge shifting bus does.
// [RULE9] Only one of the shared dac selects is active at a time, via a 2-to-4 decode.
// [RULE10] The decoder enable is inactive while the decoder address changes.
// [RULE11] The dac takes 16 bits per frame; the host sends exactly 16 falling edges.
// [RULE12] A frame cut short is dropped by the dac; the host never raises select early.
// [RULE13] After a full frame the dac loads the channel picked by the channel bit.
// [RULE14] Bit 15 is channel, 14 buffered reference, 13..12 power-down, the rest code.
module ddw_host
  import ddw_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // dac link
  output logic             host_serial_clock_out,
  output logic             dac_data_out,
  output logic      [1:0]  dec_addr,
  output logic             dec_enable_n,
  output logic      [3:0]  dac_select_n
);

  // ahb address phase capture
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        acc_ok;

  assign acc_ok = hsel && hready && htrans[1] && (hsize == 3'h2);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc_ok && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // software registers
  logic [15:0] word_q;
  logic [2:0]  ctrl_q;
  logic [1:0]  target_q;
  logic [7:0]  div_q;
  logic        done_q;
  logic        start_q;
  logic        busy;
  logic        frame_end;
  ddw_state_t  state_q;

  assign busy = (state_q != DDW_IDLE) || start_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      word_q   <= DDW_WORD_RST;
      ctrl_q   <= DDW_CTRL_RST;
      target_q <= DDW_TGT_RST;
      div_q    <= DDW_DIV_RST;
    end else if (wr_pend_q && !busy) begin
      case (wr_addr_q)
        DDW_OFF_CTRL: begin
          ctrl_q <= {hwdata[DDW_CTRL_BYTE_MODE], hwdata[DDW_CTRL_LSB_PORT], 1'b0};
        end
        DDW_OFF_WORD: begin
          word_q <= hwdata[15:0]; // [RULE14]
        end
        DDW_OFF_TARGET: begin
          target_q <= hwdata[1:0];
        end
        DDW_OFF_DIV: begin
          div_q <= (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // start request, taken only while idle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_q <= 1'b0;
    end else if (wr_pend_q && !busy && wr_addr_q == DDW_OFF_CTRL) begin
      start_q <= hwdata[DDW_CTRL_START];
    end else if (state_q == DDW_IDLE) begin
      start_q <= 1'b0;
    end
  end

  // sticky done, write one to clear; a new completion wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (frame_end) begin
      done_q <= 1'b1;
    end else if (wr_pend_q && wr_addr_q == DDW_OFF_STATUS && hwdata[DDW_STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // read data prepared in the address phase, zero wait states
  logic [31:0] rd_d;

  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      DDW_OFF_CTRL:   rd_d = {29'h0, ctrl_q[2:1], 1'b0};
      DDW_OFF_WORD:   rd_d = {16'h0, word_q};
      DDW_OFF_TARGET: rd_d = {30'h0, target_q};
      DDW_OFF_DIV:    rd_d = {24'h0, div_q};
      DDW_OFF_STATUS: rd_d = {30'h0, done_q, busy};
      default:        rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc_ok && !hwrite) begin
        hrdata <= rd_d;
      end
    end
  end

  // bit reversal for a port that shifts least significant bit first
  function automatic logic [7:0] ddw_rev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < DDW_BYTE_BITS; i++) begin
      r[i] = b[DDW_BYTE_BITS-1-i];
    end
    return r;
  endfunction

  // link sequencer
  logic [7:0]  cnt_q;
  logic [15:0] shreg_q;
  logic [4:0]  bits_q;
  logic        lsb_port_q;
  logic        byte_mode_q;
  logic        tick;
  logic        out_bit;

  assign tick      = (cnt_q == 8'h00);
  assign frame_end = (state_q == DDW_RECOVER) && tick;
  // a least-first port emits bit 0, its bytes were reversed at load
  assign out_bit   = lsb_port_q ? shreg_q[0] : shreg_q[15]; // [RULE6] [RULE7]

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (tick || state_q == DDW_IDLE) begin
      cnt_q <= div_q - 8'h01;
    end else begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= DDW_IDLE;
    end else begin
      case (state_q)
        DDW_IDLE: begin
          if (start_q) begin
            state_q <= DDW_ADDR;
          end
        end
        DDW_ADDR: begin
          if (tick) begin
            state_q <= DDW_SETUP; // [RULE10]
          end
        end
        DDW_SETUP: begin
          if (tick) begin
            state_q <= DDW_HIGH; // [RULE3]
          end
        end
        DDW_HIGH: begin
          if (tick) begin
            state_q <= DDW_LOW;
          end
        end
        DDW_LOW: begin
          if (tick) begin
            if (bits_q == 5'(DDW_FRAME_BITS)) begin
              state_q <= DDW_HOLD; // [RULE11]
            end else if (byte_mode_q && bits_q == 5'(DDW_BYTE_BITS)) begin
              state_q <= DDW_GAP; // [RULE4]
            end else begin
              state_q <= DDW_HIGH;
            end
          end
        end
        DDW_GAP: begin
          if (tick) begin
            state_q <= DDW_HIGH;
          end
        end
        DDW_HOLD: begin
          if (tick) begin
            state_q <= DDW_RECOVER; // [RULE5] [RULE12]
          end
        end
        DDW_RECOVER: begin
          if (tick) begin
            state_q <= DDW_IDLE;
          end
        end
        default: begin
          state_q <= DDW_IDLE;
        end
      endcase
    end
  end

  // shift register and falling-edge count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shreg_q     <= 16'h0000;
      bits_q      <= 5'h00;
      lsb_port_q  <= 1'b0;
      byte_mode_q <= 1'b0;
    end else if (state_q == DDW_IDLE && start_q) begin
      lsb_port_q  <= ctrl_q[DDW_CTRL_LSB_PORT];
      byte_mode_q <= ctrl_q[DDW_CTRL_BYTE_MODE];
      bits_q      <= 5'h00;
      if (ctrl_q[DDW_CTRL_LSB_PORT]) begin
        shreg_q <= {ddw_rev8(word_q[7:0]), ddw_rev8(word_q[15:8])}; // [RULE7]
      end else begin
        shreg_q <= word_q; // [RULE13] [RULE14]
      end
    end else if (state_q == DDW_HIGH && tick) begin
      bits_q <= bits_q + 5'h01;
      if (lsb_port_q) begin
        shreg_q <= {1'b0, shreg_q[15:1]};
      end else begin
        shreg_q <= {shreg_q[14:0], 1'b0};
      end
    end
  end

  // serial clock and data pins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      host_serial_clock_out <= 1'b0;
      dac_data_out          <= 1'b0;
    end else begin
      if (state_q == DDW_SETUP && tick) begin
        dac_data_out <= out_bit; // [RULE2]
      end else if (state_q == DDW_LOW && tick && bits_q != 5'(DDW_FRAME_BITS)) begin
        dac_data_out <= out_bit; // [RULE8]
      end else if (state_q == DDW_GAP && tick) begin
        dac_data_out <= out_bit;
      end
      if (state_q == DDW_SETUP && tick) begin
        host_serial_clock_out <= 1'b1;
      end else if (state_q == DDW_HIGH && tick) begin
        host_serial_clock_out <= 1'b0; // [RULE1]
      end else if (state_q == DDW_LOW && tick && bits_q != 5'(DDW_FRAME_BITS)
                   && !(byte_mode_q && bits_q == 5'(DDW_BYTE_BITS))) begin
        host_serial_clock_out <= 1'b1;
      end else if (state_q == DDW_GAP && tick) begin
        host_serial_clock_out <= 1'b1;
      end
    end
  end

  // decoder address, enable and decoded selects
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dec_addr     <= 2'h0;
      dec_enable_n <= 1'b1;
      dac_select_n <= 4'hF;
    end else begin
      if (state_q == DDW_IDLE && start_q) begin
        dec_addr <= target_q; // [RULE10]
      end
      if (state_q == DDW_ADDR && tick) begin
        dec_enable_n <= 1'b0;
        dac_select_n <= ~(4'h1 << target_q); // [RULE9]
      end else if (state_q == DDW_HOLD && tick) begin
        dec_enable_n <= 1'b1; // [RULE5]
        dac_select_n <= 4'hF;
      end
    end
  end

endmodule // ddw_host

// [core/ddw_pkg.sv]
// package of constants for the dual dac serial host writer
package ddw_pkg;
  // register byte offsets
  localparam logic [7:0] DDW_OFF_CTRL   = 8'h00;
  localparam logic [7:0] DDW_OFF_WORD   = 8'h04;
  localparam logic [7:0] DDW_OFF_TARGET = 8'h08;
  localparam logic [7:0] DDW_OFF_DIV    = 8'h0C;
  localparam logic [7:0] DDW_OFF_STATUS = 8'h10;
  // control field positions
  localparam int DDW_CTRL_START    = 0;
  localparam int DDW_CTRL_LSB_PORT = 1;
  localparam int DDW_CTRL_BYTE_MODE = 2;
  // status field positions
  localparam int DDW_STAT_BUSY = 0;
  localparam int DDW_STAT_DONE = 1;
  // control word field positions
  localparam int DDW_W_CHANNEL = 15;
  localparam int DDW_W_BUFREF  = 14;
  localparam int DDW_W_PD_HI   = 13;
  localparam int DDW_W_PD_LO   = 12;
  // frame geometry
  localparam int DDW_FRAME_BITS = 16;
  localparam int DDW_BYTE_BITS  = 8;
  localparam int DDW_TARGETS    = 4;
  // reset values
  localparam logic [15:0] DDW_WORD_RST = 16'h0000;
  localparam logic [2:0]  DDW_CTRL_RST = 3'h0;
  localparam logic [1:0]  DDW_TGT_RST  = 2'h0;
  // timing: serial clock half period, default 24 ns at 125 MHz core clock
  localparam int DDW_CORE_PERIOD_PS = 8000;
  localparam int DDW_HALF_NS        = 24;
  localparam int DDW_HALF_CYC       =
    (DDW_HALF_NS * 1000 + DDW_CORE_PERIOD_PS - 1) / DDW_CORE_PERIOD_PS;
  localparam logic [7:0] DDW_DIV_RST = 8'(DDW_HALF_CYC);
  // link sequencer states
  typedef enum logic [3:0] {
    DDW_IDLE    = 4'b0000,
    DDW_ADDR    = 4'b0001,
    DDW_SETUP   = 4'b0010,
    DDW_HIGH    = 4'b0011,
    DDW_LOW     = 4'b0100,
    DDW_GAP     = 4'b0101,
    DDW_HOLD    = 4'b0110,
    DDW_RECOVER = 4'b0111
  } ddw_state_t;
endpackage

// [verif/ddw_dac_model.sv]
// behavioural model of four dual dacs on shared clock and data
`timescale 1ns/10ps
module ddw_dac_model (
  // link pins
  input wire logic        sclk,
  input wire logic        din,
  input wire logic [3:0]  sel_n,
  // last loaded word
  output logic     [1:0]  rx_tgt,
  output logic     [15:0] rx_word,
  output int              rx_cnt
);
  logic [15:0] sh;
  logic [11:0] code_q [4][2];
  int          n;
  // a new frame needs select high first; a short frame is dropped
  always @(sel_n) begin
    if (sel_n == 4'hF) n = 0;
  end
  always @(negedge sclk) begin
    if (sel_n != 4'hF && n < 16) begin
      sh = {sh[14:0], din};
      n++;
      if (n == 16) begin
        for (int i = 0; i < 4; i++) if (!sel_n[i]) rx_tgt = 2'(i);
        code_q[rx_tgt][sh[15]] = sh[11:0];
        rx_word = sh;
        rx_cnt++;
      end
    end
  end
endmodule // ddw_dac_model

// [verif/ddw_host_assertions.sv]
// concurrent checks on the dac link pins and the bus answer of the host
`timescale 1ns/10ps
module ddw_host_checker (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // bus answer
  input wire logic       hreadyout,
  input wire logic       hresp,
  // dac link
  input wire logic       host_serial_clock_out,
  input wire logic       dac_data_out,
  input wire logic [1:0] dec_addr,
  input wire logic       dec_enable_n,
  input wire logic [3:0] dac_select_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [4:0] fall_q;
  // falling serial clock edges seen in the open frame
  always_ff @(posedge core_clk) begin
    if (rst || dec_enable_n) fall_q <= 5'h00;
    else if ($fell(host_serial_clock_out)) fall_q <= fall_q + 5'h01;
  end
  sequence enable_drop;
    $fell(dec_enable_n);
  endsequence
  // with a one-cycle half period the clock may rise on the very next edge
  sequence clock_held_low;
    (!host_serial_clock_out && fall_q == 5'h00) ##1 !dec_enable_n;
  endsequence
  idle_clock_low_a: assert property (dec_enable_n |-> !host_serial_clock_out)
    else $error("serial clock not low outside a frame");
  data_stable_a: assert property ($fell(host_serial_clock_out) |-> $stable(dac_data_out))
    else $error("data moved at the falling clock edge");
  select_first_a: assert property (enable_drop |-> clock_held_low)
    else $error("clock rose too soon after select fell");
  sixteen_falls_a: assert property ($rose(dec_enable_n) |-> fall_q == 5'h10)
    else $error("frame closed without exactly sixteen falls");
  no_extra_fall_a: assert property ($fell(host_serial_clock_out) |-> !dec_enable_n && fall_q < 5'h10)
    else $error("clock fall outside a sixteen bit frame");
  one_select_a: assert property ($onehot0(~dac_select_n))
    else $error("more than one select low");
  select_decode_a: assert property (dac_select_n == (dec_enable_n ? 4'hF : ~(4'h1 << dec_addr)))
    else $error("select does not match decoder inputs");
  addr_quiet_a: assert property ($changed(dec_addr) |-> dec_enable_n && $past(dec_enable_n))
    else $error("decoder address moved while enabled");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule // ddw_host_checker

bind ddw_host ddw_host_checker u_ddw_host_checker (
  .core_clk(core_clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .host_serial_clock_out(host_serial_clock_out), .dac_data_out(dac_data_out),
  .dec_addr(dec_addr), .dec_enable_n(dec_enable_n), .dac_select_n(dac_select_n));

// [verif/tb_dual_dac_serial_host_writer.sv]
// self-checking bench for the dac serial host writer
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_dual_dac_serial_host_writer;
  import ddw_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, sclk, din, den_n;
  logic [1:0]  dadr, rx_tgt;
  logic [3:0]  sel_n;
  logic [15:0] rx_word, w;
  logic [17:0] e;
  logic [31:0] seed = 32'h4F5603A6;
  int          rx_cnt, k;
  int          err_total = 0;
  int          n_compared = 0;
  logic [17:0] expq[$];
  ddw_host u_ddw_host (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .host_serial_clock_out(sclk),
    .dac_data_out(din), .dec_addr(dadr), .dec_enable_n(den_n), .dac_select_n(sel_n));
  ddw_dac_model u_ddw_dac_model (.sclk(sclk), .din(din), .sel_n(sel_n),
    .rx_tgt(rx_tgt), .rx_word(rx_word), .rx_cnt(rx_cnt));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic test_done(input bit hang);
    if (hang) err_total++;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 64; i++) begin
      @(posedge core_clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 64) test_done(1'b1);
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    bus(a, 1'b0, 32'h0);
    `CHK(rd, x);
  endtask
  // each load seen at the dac takes the oldest noted word
  always @(rx_cnt) begin
    // let the model's word and target ports settle before they are read
    #1;
    e = expq.size() > 0 ? expq.pop_front() : 18'hX;
    `CHK({rx_tgt, rx_word}, e);
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 6; i++) rdc(8'(i * 4), i == 3 ? 32'(DDW_DIV_RST) : 32'h0);
    bus(DDW_OFF_DIV, 1'b1, 32'h0);
    rdc(DDW_OFF_DIV, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      w = 16'(rnd());
      bus(DDW_OFF_WORD, 1'b1, {16'h0, w});
      bus(DDW_OFF_TARGET, 1'b1, 32'(i % 4));
      bus(DDW_OFF_DIV, 1'b1, rnd() % 4 + 32'h1);
      expq.push_back({2'(i % 4), w});
      bus(DDW_OFF_CTRL, 1'b1, 32'(i / 4 * 2 + 1));
      rdc(DDW_OFF_STATUS, 32'h1);
      bus(DDW_OFF_WORD, 1'b1, {16'h0, ~w});
      rd = 32'h0;
      for (k = 0; k < 200 && rd[1] !== 1'b1; k++) bus(DDW_OFF_STATUS, 1'b0, 32'h0);
      if (k == 200) test_done(1'b1);
      `CHK(rd, 32'h2);
      rdc(DDW_OFF_WORD, {16'h0, w});
      bus(DDW_OFF_STATUS, 1'b1, 32'h2);
      rdc(DDW_OFF_STATUS, 32'h0);
      $display("test frame %0d done", i);
    end
    `CHK(expq.size(), 0);
    test_done(1'b0);
  end
endmodule // tb_dual_dac_serial_host_writer
